/* src/i2crs_fifo.sv */
// Shift-register FIFO with valid and ready on both sides.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module i2crs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   typedef struct packed {
      logic [DEPTH-1:0]            vld;
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } i2crs_fifo_st_t;

   i2crs_fifo_st_t q;
   i2crs_fifo_st_t d;
   logic           placed;

   always_comb begin
      d      = q;
      placed = 1'b0;
      if (q.vld[0] && out_ready) begin
         d.vld = {1'b0, q.vld[DEPTH-1:1]};
         d.mem = {{WIDTH{1'b0}}, q.mem[DEPTH-1:1]};
      end
      if (in_valid && !q.vld[DEPTH-1]) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (!placed && !d.vld[i]) begin
               d.vld[i] = 1'b1;
               d.mem[i] = in_data;
               placed   = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready  = !q.vld[DEPTH-1];
   assign out_valid = q.vld[0];
   assign out_data  = q.mem[0];

endmodule // i2crs_fifo

/* src/i2crs_filt.sv */
// Input conditioner for one bus line: two-flop synchroniser, then spike filter.
// Assumes the line is asynchronous to clock and idles high.
`timescale 1ns/1ps
module i2crs_filt (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic line_i,
   input  wire logic hs,
   output logic      line_f
);

   i2crs_pkg::i2crs_filt_t q;
   i2crs_pkg::i2crs_filt_t d;
   logic [1:0]             lim;

   always_comb begin
      d     = q;
      d.s1  = line_i;
      d.s2  = q.s1;
      lim   = hs ? i2crs_pkg::HS_FILT_LIM : i2crs_pkg::LS_FILT_LIM; // RULE5
      if (q.s2 == q.out) begin
         d.cnt = 2'h0;
      end else if (q.cnt == lim) begin
         d.out = q.s2;
         d.cnt = 2'h0;
      end else begin
         d.cnt = q.cnt + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= i2crs_pkg::FILT_RST;
      end else begin
         q <= d;
      end
   end

   assign line_f = q.out;

endmodule // i2crs_filt

/* src/i2crs_pkg.sv */
// Constants and types shared by the two-wire register access slave.
// Assumes a 50 MHz system clock; all figures below are fixed by the hardware.
package i2crs_pkg;

   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 20;

   // Highest bus rates served, in kHz: standard, fast, fast plus, high speed.
   localparam int SCL_STD_KHZ   = 100;
   localparam int SCL_FAST_KHZ  = 400;
   localparam int SCL_FPLUS_KHZ = 1000;
   localparam int SCL_HS_KHZ    = 3400;

   // Spike suppression of the low-speed and high-speed input filter sets.
   localparam int LS_SPIKE_NS = 50;
   localparam int HS_SPIKE_NS = 10;
   localparam int LS_FILT_CYC = (LS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HS_FILT_CYC = (HS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] LS_FILT_LIM = 2'(LS_FILT_CYC - 1);
   localparam logic [1:0] HS_FILT_LIM = 2'(HS_FILT_CYC - 1);

   // Bus addresses chosen by the phase configuration pins.
   localparam logic [6:0] SLV_ADDR_LOW  = 7'h30;
   localparam logic [6:0] SLV_ADDR_HIGH = 7'h34;

   // High-speed master code 00001xxx: only the top five bits are compared.
   localparam logic [4:0] MCODE_PAT = 5'h01;

   // Register pointer value after reset and after every STOP.
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Bit counts within one byte.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   // Write queue shape: register index and data byte per entry.
   localparam int WFIFO_WIDTH = 16;
   localparam int WFIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      I2CRS_IDLE,
      I2CRS_ADDR,
      I2CRS_MCODE,
      I2CRS_AACK,
      I2CRS_WR,
      I2CRS_WACK,
      I2CRS_RD,
      I2CRS_RACK
   } i2crs_state_t;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       out;
      logic [1:0] cnt;
   } i2crs_filt_t;

   localparam i2crs_filt_t FILT_RST = '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 2'h0};

   typedef struct packed {
      i2crs_state_t st;
      logic         scl_prev;
      logic         sda_prev;
      logic [2:0]   cfg_s1;
      logic [2:0]   cfg_s2;
      logic [3:0]   bitcnt;
      logic [7:0]   shreg;
      logic [7:0]   ptr;
      logic         rw;
      logic         got_ptr;
      logic         wpend;
      logic         more;
      logic         hs;
      logic         sda_oe;
      logic         sda_o;
      logic         push;
      logic [7:0]   waddr;
      logic [7:0]   wdat;
   } i2crs_slv_t;

   localparam i2crs_slv_t SLV_RST = '{
      st: I2CRS_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, cfg_s1: 3'h0, cfg_s2: 3'h0,
      bitcnt: 4'h0, shreg: 8'h00, ptr: PTR_RESET, rw: 1'b0, got_ptr: 1'b0,
      wpend: 1'b0, more: 1'b0, hs: 1'b0, sda_oe: 1'b0, sda_o: 1'b0, push: 1'b0,
      waddr: 8'h00, wdat: 8'h00};

endpackage

/* src/i2crs_slave.sv */
// Two-wire bus slave giving a bus master byte access to an 8-bit register space.
// Assumes a register file on the same clock: it answers rd_addr combinationally
// on rd_data and drains queued writes through wr_valid and wr_ready.
//
// Contract
// (RULE1) Serve bus rates from zero to 3.4 MHz.
// (RULE2) Never hold the clock line low.
// (RULE3) Low-speed filters after reset and every STOP.
// (RULE4) Only the master code selects high-speed filters.
// (RULE5) High-speed mode uses a separate filter set.
// (RULE6) STOP restores low-speed; repeated START keeps filters.
// (RULE7) Single write: address, pointer, data, all acknowledged.
// (RULE8) Data byte takes effect at acknowledge rising edge.
// (RULE9) Sequential write stores bytes in successive registers.
// (RULE10) Pair mode: pointer then data, repeated.
// (RULE11) Single read: acknowledge address, send pointed byte.
// (RULE12) Master acknowledge fetches the next register byte.
// (RULE13) Master ends every read with not-acknowledge.
// (RULE14) Every STOP resets the register pointer to zero.
// (RULE15) Master may read register zero right after STOP.
// (RULE16) General call address is never acknowledged.
// (RULE17) Address from three phase pins; top pin dominates.
// (RULE18) After STOP or mismatch, wait for START.
// (RULE19) Master code 00001xxx is refused, then high speed.
// (RULE20) Pointer advances by one after each data byte; a byte written in pair mode leaves it unchanged.
`timescale 1ns/1ps
module i2crs_slave (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       phase_config_pin_0,
   input  wire logic       phase_config_pin_1,
   input  wire logic       phase_config_pin_2,
   input  wire logic       pair_mode,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data,
   output logic            wr_valid,
   input  wire logic       wr_ready,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            hs_mode
);

   i2crs_pkg::i2crs_slv_t q;
   i2crs_pkg::i2crs_slv_t d;

   logic        scl_f;
   logic        sda_f;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [6:0]  own_addr;
   logic        fifo_rdy;
   logic [15:0] fifo_out;

   // Both lines pass the synchroniser and the filter set chosen by the mode.
   i2crs_filt u_scl_filt (
      .clock  (clock),
      .rst_n  (rst_n),
      .line_i (scl_i),
      .hs     (q.hs),
      .line_f (scl_f)
   ); // RULE1

   i2crs_filt u_sda_filt (
      .clock  (clock),
      .rst_n  (rst_n),
      .line_i (sda_i),
      .hs     (q.hs),
      .line_f (sda_f)
   ); // RULE5

   // Received writes queue here until the register file takes them.
   i2crs_fifo #(
      .WIDTH (i2crs_pkg::WFIFO_WIDTH),
      .DEPTH (i2crs_pkg::WFIFO_DEPTH)
   ) u_wfifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (q.push),
      .in_ready  (fifo_rdy),
      .in_data   ({q.waddr, q.wdat}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (fifo_out)
   );

   assign wr_addr = fifo_out[15:8];
   assign wr_data = fifo_out[7:0];

   // Bus events seen on the filtered lines.
   assign scl_rise  = scl_f && !q.scl_prev;
   assign scl_fall  = !scl_f && q.scl_prev;
   assign start_det = scl_f && q.scl_prev && q.sda_prev && !sda_f;
   assign stop_det  = scl_f && q.scl_prev && !q.sda_prev && sda_f;

   // Own address from the synchronised phase pins.
   assign own_addr = q.cfg_s2[2] ? i2crs_pkg::SLV_ADDR_HIGH
                   : (i2crs_pkg::SLV_ADDR_LOW | {5'h00, q.cfg_s2[1:0]}); // RULE17

   always_comb begin
      d          = q;
      d.scl_prev = scl_f;
      d.sda_prev = sda_f;
      d.cfg_s1   = {phase_config_pin_2, phase_config_pin_1, phase_config_pin_0};
      d.cfg_s2   = q.cfg_s1;
      d.push     = 1'b0;
      if (start_det) begin
         // A repeated START leaves the filter selection untouched.
         d.st      = i2crs_pkg::I2CRS_ADDR; // RULE6
         d.bitcnt  = 4'h0;
         d.sda_oe  = 1'b0;
         d.got_ptr = 1'b0;
         d.wpend   = 1'b0;
      end else if (stop_det) begin
         d.st      = i2crs_pkg::I2CRS_IDLE; // RULE18
         d.ptr     = i2crs_pkg::PTR_RESET; // RULE14
         d.hs      = 1'b0; // RULE3
         d.sda_oe  = 1'b0;
         d.got_ptr = 1'b0;
         d.wpend   = 1'b0;
      end else begin
         unique case (q.st)
            i2crs_pkg::I2CRS_IDLE: begin
               // Clock edges are ignored until the next START.
               d.st = i2crs_pkg::I2CRS_IDLE; // RULE18
            end
            i2crs_pkg::I2CRS_ADDR: begin
               if (scl_rise) begin
                  d.shreg  = {q.shreg[6:0], sda_f};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == i2crs_pkg::BITS_PER_BYTE) begin
                  if (q.shreg[7:3] == i2crs_pkg::MCODE_PAT) begin
                     d.st = i2crs_pkg::I2CRS_MCODE; // RULE19
                  end else if (q.shreg[7:1] == own_addr) begin
                     d.sda_oe = 1'b1; // RULE7
                     d.rw     = q.shreg[0];
                     d.st     = i2crs_pkg::I2CRS_AACK;
                  end else begin
                     // Mismatch and general call stay released.
                     d.st = i2crs_pkg::I2CRS_IDLE; // RULE16
                  end
               end
            end
            i2crs_pkg::I2CRS_MCODE: begin
               // The master code is left unacknowledged, then the fast filters engage.
               if (scl_fall) begin
                  d.hs = 1'b1; // RULE4
                  d.st = i2crs_pkg::I2CRS_IDLE; // RULE19
               end
            end
            i2crs_pkg::I2CRS_AACK: begin
               if (scl_fall) begin
                  d.bitcnt = 4'h0;
                  if (q.rw) begin
                     d.shreg  = rd_data; // RULE11
                     d.sda_oe = !rd_data[7];
                     d.st     = i2crs_pkg::I2CRS_RD;
                  end else begin
                     d.sda_oe = 1'b0;
                     d.st     = i2crs_pkg::I2CRS_WR;
                  end
               end
            end
            i2crs_pkg::I2CRS_WR: begin
               if (scl_rise) begin
                  d.shreg  = {q.shreg[6:0], sda_f};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == i2crs_pkg::BITS_PER_BYTE) begin
                  if (!q.got_ptr) begin
                     d.ptr     = q.shreg; // RULE7
                     d.got_ptr = 1'b1;
                     d.sda_oe  = 1'b1;
                     d.st      = i2crs_pkg::I2CRS_WACK;
                  end else if (fifo_rdy) begin
                     d.wpend  = 1'b1; // RULE9
                     d.sda_oe = 1'b1;
                     d.st     = i2crs_pkg::I2CRS_WACK;
                  end else begin
                     // A full queue refuses the byte rather than stretch the clock.
                     d.sda_oe = 1'b0; // RULE2
                     d.st     = i2crs_pkg::I2CRS_IDLE;
                  end
               end
            end
            i2crs_pkg::I2CRS_WACK: begin
               if (scl_rise && q.wpend) begin
                  d.push  = 1'b1; // RULE8
                  d.waddr = q.ptr;
                  d.wdat  = q.shreg;
                  d.wpend = 1'b0;
                  if (pair_mode) begin
                     d.got_ptr = 1'b0; // RULE10
                  end else begin
                     d.ptr = q.ptr + 8'h01; // RULE20
                  end
               end else if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.bitcnt = 4'h0;
                  d.st     = i2crs_pkg::I2CRS_WR;
               end
            end
            i2crs_pkg::I2CRS_RD: begin
               if (scl_fall) begin
                  if (q.bitcnt < i2crs_pkg::LAST_TX_BIT) begin
                     d.shreg  = {q.shreg[6:0], 1'b0};
                     d.sda_oe = !q.shreg[6];
                     d.bitcnt = q.bitcnt + 4'h1;
                  end else begin
                     d.sda_oe = 1'b0;
                     d.ptr    = q.ptr + 8'h01; // RULE20
                     d.st     = i2crs_pkg::I2CRS_RACK;
                  end
               end
            end
            i2crs_pkg::I2CRS_RACK: begin
               if (scl_rise) begin
                  d.more = !sda_f;
               end else if (scl_fall) begin
                  if (q.more) begin
                     d.shreg  = rd_data; // RULE12
                     d.sda_oe = !rd_data[7];
                     d.bitcnt = 4'h0;
                     d.st     = i2crs_pkg::I2CRS_RD;
                  end else begin
                     // A not-acknowledge ends the read; wait for STOP or START.
                     d.st = i2crs_pkg::I2CRS_IDLE; // RULE13
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= i2crs_pkg::SLV_RST; // RULE3
      end else begin
         q <= d;
      end
   end

   assign sda_o   = q.sda_o;
   assign sda_oe  = q.sda_oe;
   assign rd_addr = q.ptr;
   assign hs_mode = q.hs;

endmodule // i2crs_slave

/* tb/i2crs_checker.sv */
// Concurrent checks on the ports of the two-wire register access slave.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module i2crs_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [7:0] rd_addr,
   input wire logic       wr_valid,
   input wire logic       wr_ready,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic       hs_mode
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   open_drain_a: assert property (sda_o == 1'b0)
      else $error("data output not held low");
   reset_exit_a: assert property ($rose(rst_n) |-> !sda_oe && !hs_mode && !wr_valid
      && rd_addr == 8'h00)
      else $error("state after reset wrong");
   head_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr)
      && $stable(wr_data))
      else $error("queued write lost while stalled");
   push_ack_a: assert property ($rose(wr_valid) |-> sda_oe)
      else $error("write queued outside acknowledge");
   hs_entry_a: assert property ($rose(hs_mode) |-> !sda_oe)
      else $error("master code acknowledged");
   hs_exit_a: assert property ($fell(hs_mode) |-> ##[0:2] rd_addr == 8'h00)
      else $error("pointer not cleared on stop");
   sda_stand_a: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*3])
      else $error("data drive too short");
   hs_steady_a: assert property (sda_oe && $past(sda_oe) |-> $stable(hs_mode))
      else $error("filter set changed mid byte");
endmodule // i2crs_checker

bind i2crs_slave i2crs_checker i_chk (
   .clock(clock), .rst_n(rst_n), .sda_o(sda_o), .sda_oe(sda_oe), .rd_addr(rd_addr),
   .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
   .hs_mode(hs_mode));

/* tb/i2crs_master.sv */
// Behavioural bus master: makes the clock line and drives data open drain.
// Assumes the bench ands the released data level with the slave's pull-down.
`timescale 1ns/1ps
module i2crs_master (
   input  wire logic clock,
   input  wire logic fast,
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Start or repeated start; waits for the slave to release data first.
   task automatic start();
      tick(2);
      sda_m = 1'b1;
      tick(6);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b0;
      tick(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_m = 1'b0;
      tick(6);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b1;
      tick(8);
   endtask
   // One bit: 320 ns at low speed, 160 ns once fast is set; read late in the high phase.
   // The low phase outlasts the slave's synchroniser and filter delay, so its data moves first.
   task automatic bit_io(input logic b, output logic s);
      int lo;
      int hi;
      lo = fast ? 5 : 8;
      hi = fast ? 3 : 8;
      tick(lo - 1);
      sda_m = b;
      tick(1);
      scl = 1'b1;
      tick(hi - 1);
      s = sda_line;
      tick(1);
      scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule // i2crs_master

/* tb/i2crs_slave_tb.sv */
// Self-checking bench with a bus master model and a stallable register file.
// Assumes a 50 MHz clock and an open-drain data wire with a pull-up.
`timescale 1ns/1ps
module i2crs_slave_tb;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic       scl;
   logic       sda_m;
   logic       sda_i;
   logic       sda_o;
   logic       sda_oe;
   logic       phase_config_pin_0 = 1'b0;
   logic       phase_config_pin_1 = 1'b0;
   logic       phase_config_pin_2 = 1'b0;
   logic       pair_mode = 1'b0;
   logic       fast = 1'b0;
   logic       wr_ready = 1'b1;
   logic       wr_valid;
   logic       hs_mode;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] regs [256];
   logic [7:0] exp_q [256];
   int         num_errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   assign sda_i = sda_m & ~sda_oe;
   assign rd_data = regs[rd_addr];
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (wr_valid && wr_ready) begin
         regs[wr_addr] <= wr_data;
      end
      if (cyc == 40000) begin
         num_errors++;
         results();
      end
   end

   i2crs_master i_mst (
      .clock(clock), .fast(fast), .scl(scl), .sda_m(sda_m), .sda_line(sda_i));
   i2crs_slave i_dut (
      .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
      .sda_oe(sda_oe), .phase_config_pin_0(phase_config_pin_0),
      .phase_config_pin_1(phase_config_pin_1), .phase_config_pin_2(phase_config_pin_2),
      .pair_mode(pair_mode), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .hs_mode(hs_mode));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic sb(input logic [7:0] b, input logic exp_ack);
      logic a;
      i_mst.send_byte(b, a);
      check("acknowledge", {7'h00, a}, {7'h00, exp_ack});
   endtask
   task automatic rb(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      i_mst.recv_byte(last, d);
      check("read data", d, exp);
   endtask
   task automatic drain();
      for (int i = 0; i < 60 && wr_valid === 1'b1; i++) begin
         @(negedge clock);
      end
      check("queue empty", {7'h00, wr_valid}, 8'h00);
   endtask
   task automatic wr_seq(input logic [7:0] p, input int n, input int n_ack);
      logic [7:0] d;
      i_mst.start();
      sb(8'h60, 1'b1);
      sb(p, 1'b1);
      for (int k = 0; k < n; k++) begin
         d = p + 8'(k) + 8'h5A;
         sb(d, k < n_ack);
         if (k < n_ack) begin
            exp_q[p + 8'(k)] = d;
         end
      end
      i_mst.stop();
   endtask
   task automatic rd_seq(input logic [7:0] p, input int n);
      i_mst.start();
      sb(8'h60, 1'b1);
      sb(p, 1'b1);
      i_mst.start();
      sb(8'h61, 1'b1);
      for (int k = 0; k < n; k++) begin
         rb(k == n - 1, exp_q[p + 8'(k)]);
      end
      i_mst.stop();
   endtask

   task automatic t_reset();
      check("hs mode", {7'h00, hs_mode}, 8'h00);
      check("pointer", rd_addr, 8'h00);
      check("outputs", {6'h00, wr_valid, sda_oe}, 8'h00);
   endtask
   task automatic t_single();
      wr_seq(8'h05, 1, 1);
      drain();
      rd_seq(8'h05, 1);
      wr_seq(8'h00, 1, 1);
      drain();
      i_mst.start();
      sb(8'h61, 1'b1);
      rb(1'b1, exp_q[0]);
      i_mst.stop();
      check("pointer after stop", rd_addr, 8'h00);
   endtask
   task automatic t_full();
      wr_ready = 1'b0;
      wr_seq(8'h40, 9, 8);
      check("queue held", {7'h00, wr_valid}, 8'h01);
      wr_ready = 1'b1;
      drain();
      rd_seq(8'h40, 9);
   endtask
   task automatic t_pair();
      pair_mode = 1'b1;
      i_mst.start();
      sb(8'h60, 1'b1);
      sb(8'h20, 1'b1);
      sb(8'h11, 1'b1);
      sb(8'h08, 1'b1);
      sb(8'h22, 1'b1);
      i_mst.stop();
      pair_mode = 1'b0;
      exp_q[8'h20] = 8'h11;
      exp_q[8'h08] = 8'h22;
      drain();
      rd_seq(8'h08, 1);
      rd_seq(8'h20, 2);
   endtask
   task automatic t_address();
      i_mst.start();
      sb(8'h00, 1'b0);
      sb(8'h60, 1'b0);
      i_mst.stop();
      phase_config_pin_2 = 1'b1;
      phase_config_pin_0 = 1'b1;
      i_mst.start();
      sb(8'h60, 1'b0);
      i_mst.start();
      sb(8'h68, 1'b1);
      i_mst.stop();
      phase_config_pin_2 = 1'b0;
      i_mst.start();
      sb(8'h62, 1'b1);
      i_mst.stop();
      phase_config_pin_0 = 1'b0;
   endtask
   task automatic t_hs();
      i_mst.start();
      sb(8'h09, 1'b0);
      i_mst.start();
      check("hs after code", {7'h00, hs_mode}, 8'h01);
      fast = 1'b1;
      sb(8'h60, 1'b1);
      sb(8'h30, 1'b1);
      sb(8'h77, 1'b1);
      i_mst.start();
      check("hs after restart", {7'h00, hs_mode}, 8'h01);
      sb(8'h60, 1'b1);
      sb(8'h30, 1'b1);
      i_mst.start();
      sb(8'h61, 1'b1);
      rb(1'b1, 8'h77);
      i_mst.stop();
      fast = 1'b0;
      check("hs after stop", {7'h00, hs_mode}, 8'h00);
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      foreach (regs[i]) begin
         regs[i] = 8'h00;
         exp_q[i] = 8'h00;
      end
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      t_reset();
      t_single();
      t_full();
      t_pair();
      t_address();
      t_hs();
      results();
   end
endmodule // i2crs_slave_tb
